// ===== src/uvr_defs.svh
`ifndef UVR_DEFS_SVH
`define UVR_DEFS_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define UVR_ADDR_STATUS     3'h0
`define UVR_ADDR_THERMAL    3'h1
`define UVR_ADDR_MRES1      3'h2
`define UVR_ADDR_MRES3      3'h4
`define UVR_ADDR_SPAN_LO    3'h5
`define UVR_ADDR_SPAN_HI    3'h6

// ****************************************************************
// status byte bit positions
// ****************************************************************
`define UVR_ST_SPAN_OF      7
`define UVR_ST_MRES_OF      6
`define UVR_ST_ADC_OF       5
`define UVR_ST_LOST         4
`define UVR_ST_FRESH        3
`define UVR_ST_NOTREADY     2
`define UVR_ST_STANDBY      1
`define UVR_ST_PDOWN        0

// ****************************************************************
// bank layout and thermal limits
// ****************************************************************
`define UVR_BANK_WORDS      6
`define UVR_IDX_THERMAL     0
`define UVR_IDX_MRES1       1
`define UVR_IDX_SPAN_LO     4
`define UVR_IDX_SPAN_HI     5
`define UVR_TEMP_BITS       12
`define UVR_TIME_FULL_CODE  4'h2
`define UVR_SPAN_MIN_CYC    24'h001000
`define UVR_BANK_RESET      16'h0000
`define UVR_BYTE_RESET      8'h00

`endif

// ===== src/uvr_pkg.sv
package uvr_pkg;

    // read transaction phase on the serial side
    typedef enum logic {
        UVR_RD_IDLE,
        UVR_RD_ACTIVE
    } uvr_rd_state_t;

    typedef logic [15:0] uvr_word_t;
    typedef logic [7:0]  uvr_byte_t;

endpackage : uvr_pkg

// ===== src/uvr_result_status.sv
// Contract
// RULE1: overwrite unread buffer, raise lost flag
// RULE2: only status read clears lost flag
// RULE3: state bits mirror internal control signals
// RULE4: sixteen-bit results return low byte first
// RULE5: thermal word: twelve bits, top nibble zero
// RULE6: short integration gives coarser thermal result
// RULE7: sync mode, span counter off: no thermal
// RULE8: sync span under 4096 clocks: thermal invalid
// RULE9: resets and configuration clear output bank
// RULE10: measurement end fills buffer, sets fresh flag
// RULE11: read start copies buffer; frozen until stop
// RULE12: status or result read clears fresh flag
// RULE13: lost-flag set beats same-cycle clear
`timescale 1ns/1ps
`include "uvr_defs.svh"

module uvr_result_status
    import uvr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    // measurement engine side
    input  wire logic        meas_done_i,
    input  wire logic        meas_busy_i,
    input  wire logic [15:0] mres1_i,
    input  wire logic [15:0] mres2_i,
    input  wire logic [15:0] mres3_i,
    input  wire logic [11:0] temp_raw_i,
    input  wire logic [23:0] conversion_span_counter_i,
    input  wire logic        span_of_i,
    input  wire logic        mres_of_i,
    input  wire logic        adc_of_i,
    input  wire logic        standby_ctrl_i,
    input  wire logic        power_down_ctrl_i,
    // configuration
    input  wire logic [3:0]  time_code_i,
    input  wire logic        external_sync_window_mode_i,
    input  wire logic        span_measure_enable_i,
    input  wire logic [7:0]  operation_select_reg_i,
    input  wire logic        soft_reset_i,
    input  wire logic        config_state_i,
    // serial read engine side
    input  wire logic        rd_start_i,
    input  wire logic        rd_stop_i,
    input  wire logic [2:0]  rd_addr_i,
    input  wire logic        rd_byte_i,
    output uvr_byte_t        rd_data_o,
    output logic             fresh_result_flag_o,
    output logic             lost_result_flag_o,
    output logic             temp_valid_o,
    output logic             standby_actual_bit_o,
    output logic             power_down_actual_bit_o
);

    // ****************************************************************
    // thermal formatting
    // ****************************************************************
    uvr_word_t temp_word;
    logic      temp_ok;

    uvr_thermal_fmt u_thermal_fmt (
        .temp_raw_i   (temp_raw_i),
        .time_code_i  (time_code_i),
        .sync_mode_i  (external_sync_window_mode_i),
        .span_en_i    (span_measure_enable_i),
        .span_count_i (conversion_span_counter_i),
        .word_o       (temp_word),
        .valid_o      (temp_ok)
    );

    // ****************************************************************
    // storage: buffer and output bank
    // ****************************************************************
    uvr_word_t     fresh_words [0:`UVR_BANK_WORDS-1];
    uvr_word_t     buf_q       [0:`UVR_BANK_WORDS-1];
    uvr_word_t     bank_q      [0:`UVR_BANK_WORDS-1];
    logic [2:0]    buf_of_q;
    logic [2:0]    bank_of_q;
    logic          buf_tvalid_q;
    logic          buf_pending_q;
    logic          fresh_q;
    logic          lost_q;
    uvr_rd_state_t rd_state_q;
    logic [2:0]    ptr_q;
    logic          hi_q;

    // ****************************************************************
    // decode of read events
    // ****************************************************************
    wire transfer    = rd_start_i && (rd_state_q == UVR_RD_IDLE); // RULE11
    wire bank_clear  = soft_reset_i || config_state_i; // RULE9
    wire rd_status   = rd_byte_i && (ptr_q == `UVR_ADDR_STATUS) && hi_q;
    wire rd_result   = rd_byte_i && !hi_q && (ptr_q >= `UVR_ADDR_THERMAL) &&
                       (ptr_q <= `UVR_ADDR_SPAN_HI);
    // a read start in the same cycle still takes the old words, so nothing is lost
    wire overwrite   = meas_done_i && buf_pending_q && !transfer; // RULE1
    wire fresh_clr   = rd_status || rd_result; // RULE12
    wire [2:0] widx  = ptr_q - 3'h1;

    // new words offered to the buffer at measurement end
    assign fresh_words[`UVR_IDX_THERMAL] = temp_word;
    assign fresh_words[`UVR_IDX_MRES1]   = mres1_i;
    assign fresh_words[2]                = mres2_i;
    assign fresh_words[3]                = mres3_i;
    assign fresh_words[`UVR_IDX_SPAN_LO] = conversion_span_counter_i[15:0];
    assign fresh_words[`UVR_IDX_SPAN_HI] = {8'h00, conversion_span_counter_i[23:16]};

    // ****************************************************************
    // per-word buffer and bank registers
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `UVR_BANK_WORDS; gi = gi + 1) begin : g_word
            // buffer takes each finished measurement, unread or not
            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    buf_q[gi] <= `UVR_BANK_RESET;
                end else if (ce_i && meas_done_i) begin
                    buf_q[gi] <= fresh_words[gi]; // RULE10 RULE1
                end
            end
            // bank moves only at a read start or a bank clear, so it is otherwise stable during reads
            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    bank_q[gi] <= `UVR_BANK_RESET;
                end else if (ce_i && bank_clear) begin
                    bank_q[gi] <= `UVR_BANK_RESET; // RULE9
                end else if (ce_i && transfer) begin
                    bank_q[gi] <= buf_q[gi]; // RULE11
                end
            end
        end
    endgenerate

    // ****************************************************************
    // overflow and validity companions
    // ****************************************************************
    // overflow bits travel with their results so status matches the bank
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            buf_of_q     <= 3'h0;
            buf_tvalid_q <= 1'b0;
        end else if (ce_i && meas_done_i) begin
            buf_of_q     <= {span_of_i, mres_of_i, adc_of_i};
            buf_tvalid_q <= temp_ok; // RULE8
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            bank_of_q    <= 3'h0;
            temp_valid_o <= 1'b0;
        end else if (ce_i && bank_clear) begin
            bank_of_q    <= 3'h0; // RULE9
            temp_valid_o <= 1'b0;
        end else if (ce_i && transfer) begin
            bank_of_q    <= buf_of_q;
            temp_valid_o <= buf_tvalid_q; // RULE8
        end
    end

    // ****************************************************************
    // read phase and pointer
    // ****************************************************************
    // repeated start inside a read does not refresh the bank
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_state_q <= UVR_RD_IDLE;
        end else if (ce_i) begin
            case (rd_state_q)
                UVR_RD_IDLE: begin
                    if (rd_start_i) begin
                        rd_state_q <= UVR_RD_ACTIVE;
                    end
                end
                UVR_RD_ACTIVE: begin
                    if (rd_stop_i) begin
                        rd_state_q <= UVR_RD_IDLE; // RULE11
                    end
                end
                default: begin
                    rd_state_q <= UVR_RD_IDLE;
                end
            endcase
        end
    end

    // low byte first, then high byte, then next address
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ptr_q <= `UVR_ADDR_STATUS;
            hi_q  <= 1'b0;
        end else if (ce_i && rd_start_i) begin
            ptr_q <= rd_addr_i;
            hi_q  <= 1'b0;
        end else if (ce_i && rd_byte_i) begin
            hi_q  <= !hi_q; // RULE4
            if (hi_q) begin
                ptr_q <= ptr_q + 3'h1;
            end
        end
    end

    // ****************************************************************
    // data flags
    // ****************************************************************
    // pending marks buffer content not yet taken by a read start
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            buf_pending_q <= 1'b0;
        end else if (ce_i && meas_done_i) begin
            buf_pending_q <= 1'b1;
        end else if (ce_i && transfer) begin
            buf_pending_q <= 1'b0;
        end
    end

    // set wins over clear on both flags
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            fresh_q <= 1'b0;
            lost_q  <= 1'b0;
        end else if (ce_i) begin
            if (meas_done_i) begin
                fresh_q <= 1'b1; // RULE10
            end else if (fresh_clr) begin
                fresh_q <= 1'b0; // RULE12
            end
            if (overwrite) begin
                lost_q <= 1'b1; // RULE1 RULE13
            end else if (rd_status) begin
                lost_q <= 1'b0; // RULE2
            end
        end
    end

    // ****************************************************************
    // byte selection
    // ****************************************************************
    uvr_byte_t status_byte;
    uvr_word_t sel_word;
    uvr_byte_t next_byte;

    assign status_byte[`UVR_ST_SPAN_OF]  = bank_of_q[2];
    assign status_byte[`UVR_ST_MRES_OF]  = bank_of_q[1];
    assign status_byte[`UVR_ST_ADC_OF]   = bank_of_q[0];
    assign status_byte[`UVR_ST_LOST]     = lost_q;
    assign status_byte[`UVR_ST_FRESH]    = fresh_q;
    assign status_byte[`UVR_ST_NOTREADY] = meas_busy_i;
    assign status_byte[`UVR_ST_STANDBY]  = standby_ctrl_i; // RULE3
    assign status_byte[`UVR_ST_PDOWN]    = power_down_ctrl_i; // RULE3

    // address 0 gives operation select first, status second
    assign sel_word  = (ptr_q == `UVR_ADDR_STATUS) ? {status_byte, operation_select_reg_i} :
                       (ptr_q > `UVR_ADDR_SPAN_HI) ? `UVR_BANK_RESET : bank_q[widx];
    assign next_byte = hi_q ? sel_word[15:8] : sel_word[7:0]; // RULE4

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_data_o <= `UVR_BYTE_RESET;
        end else if (ce_i && rd_byte_i) begin
            rd_data_o <= next_byte;
        end
    end

    // mirrors follow the control signals, not the request bits
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            fresh_result_flag_o     <= 1'b0;
            lost_result_flag_o      <= 1'b0;
            standby_actual_bit_o    <= 1'b0;
            power_down_actual_bit_o <= 1'b0;
        end else if (ce_i) begin
            fresh_result_flag_o     <= fresh_q;
            lost_result_flag_o      <= lost_q;
            standby_actual_bit_o    <= standby_ctrl_i; // RULE3
            power_down_actual_bit_o <= power_down_ctrl_i; // RULE3
        end
    end

endmodule : uvr_result_status

// ===== src/uvr_thermal_fmt.sv
`timescale 1ns/1ps
`include "uvr_defs.svh"

// ****************************************************************
// thermal result formatter
// ****************************************************************
module uvr_thermal_fmt
    import uvr_pkg::*;
(
    input  wire logic [11:0] temp_raw_i,
    input  wire logic [3:0]  time_code_i,
    input  wire logic        sync_mode_i,
    input  wire logic        span_en_i,
    input  wire logic [23:0] span_count_i,
    output uvr_word_t        word_o,
    output logic             valid_o
);

    logic [11:0] mask;
    logic [11:0] shaped;
    logic        no_meas;
    logic        short_span;

    // short integration drops low bits; fewer clocks give fewer valid bits
    assign mask       = (time_code_i == 4'h0) ? 12'hffc :
                        (time_code_i == 4'h1) ? 12'hffe : 12'hfff; // RULE6
    assign shaped     = temp_raw_i & mask; // RULE6
    assign no_meas    = sync_mode_i && !span_en_i; // RULE7
    assign short_span = sync_mode_i && span_en_i && (span_count_i < `UVR_SPAN_MIN_CYC); // RULE8

    // upper nibble is always zero
    assign word_o  = no_meas ? `UVR_BANK_RESET : {4'h0, shaped}; // RULE5 RULE7
    assign valid_o = !no_meas && !short_span; // RULE8

endmodule : uvr_thermal_fmt

// ===== test/uvr_host_model.sv
`timescale 1ns/1ps
// ********************
// serial read host
// ********************
module uvr_host_model
    import uvr_pkg::*;
(
    input  wire logic      clk_i,
    input  wire uvr_byte_t rd_data_i,
    output logic           rd_start_o,
    output logic           rd_stop_o,
    output logic           rd_byte_o,
    output logic [2:0]     rd_addr_o
);
    initial begin
        {rd_start_o, rd_stop_o, rd_byte_o, rd_addr_o} = '0;
    end
    // every strobe is one cycle wide, raised just after an edge
    task automatic start_rd(input logic [2:0] a);
        @(posedge clk_i);
        #1;
        rd_start_o = 1'b1;
        rd_addr_o  = a;
        @(posedge clk_i);
        #1;
        rd_start_o = 1'b0;
        rd_addr_o  = ~a;  // driven to the complement: no stale address
    endtask : start_rd
    task automatic get_byte(output uvr_byte_t b);
        @(posedge clk_i);
        #1;
        rd_byte_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_byte_o = 1'b0;
        b = rd_data_i;
    endtask : get_byte
    task automatic stop_rd();
        @(posedge clk_i);
        #1;
        rd_stop_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_stop_o = 1'b0;
    endtask : stop_rd
    // low byte arrives first, then the high byte
    task automatic read_word(input logic [2:0] a, output uvr_word_t w);
        uvr_byte_t lo, hi;
        start_rd(a);
        get_byte(lo);
        get_byte(hi);
        stop_rd();
        w = {hi, lo};
    endtask : read_word
endmodule : uvr_host_model

// ===== test/uvr_result_status_asserts.sv
`timescale 1ns/1ps
// ********************
// result block checks
// ********************
module uvr_result_status_asserts
    import uvr_pkg::*;
(
    input wire logic      clk_i,
    input wire logic      rstn_i,
    input wire logic      ce_i,
    input wire logic      meas_done_i,
    input wire logic      rd_start_i,
    input wire logic      rd_byte_i,
    input wire logic      soft_reset_i,
    input wire logic      config_state_i,
    input wire logic      standby_ctrl_i,
    input wire logic      power_down_ctrl_i,
    input wire uvr_byte_t rd_data_o,
    input wire logic      fresh_result_flag_o,
    input wire logic      lost_result_flag_o,
    input wire logic      temp_valid_o,
    input wire logic      standby_actual_bit_o,
    input wire logic      power_down_actual_bit_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // strobe with no read start to move the buffer out
    sequence s_meas;
        ce_i && meas_done_i && !rd_start_i;
    endsequence
    // second strobe with no read start in between overwrites the buffer
    sequence s_overwrite;
        s_meas ##1 !rd_start_i ##1 s_meas ##1 ce_i;
    endsequence
    // flags come out one cycle behind the internal state
    a_lost_on_overwrite: assert property (s_overwrite |-> ##1 lost_result_flag_o)
        else $error("lost flag missing after overwrite");
    a_lost_kept: assert property ($fell(lost_result_flag_o) |-> $past(ce_i && rd_byte_i, 2))
        else $error("lost flag dropped without a byte fetch");
    a_fresh_on_done: assert property (ce_i && meas_done_i && !rd_byte_i ##1 ce_i |-> ##1 fresh_result_flag_o)
        else $error("fresh flag missing after measurement");
    a_fresh_kept: assert property ($fell(fresh_result_flag_o) |-> $past(ce_i && rd_byte_i, 2))
        else $error("fresh flag dropped without a byte fetch");
    a_data_stands: assert property (!rd_byte_i && !soft_reset_i && !config_state_i |=> $stable(rd_data_o))
        else $error("read byte changed without a fetch");
    a_clear_valid: assert property (ce_i && (soft_reset_i || config_state_i) && !rd_start_i |=> !temp_valid_o)
        else $error("thermal valid kept over bank clear");
    a_standby_mirror: assert property ($past(rstn_i) && $past(ce_i) |-> standby_actual_bit_o == $past(standby_ctrl_i))
        else $error("standby bit does not follow control");
    a_pdown_mirror: assert property ($past(rstn_i) && $past(ce_i) |-> power_down_actual_bit_o == $past(power_down_ctrl_i))
        else $error("power-down bit does not follow control");
endmodule : uvr_result_status_asserts

// ===== test/uvr_result_status_tb.sv
`timescale 1ns/1ps
module uvr_result_status_tb
    import uvr_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rstn_i, ce_i, meas_done_i, meas_busy_i, span_of_i, mres_of_i, adc_of_i, standby_ctrl_i;
    logic        power_down_ctrl_i, external_sync_window_mode_i, span_measure_enable_i, soft_reset_i;
    logic        config_state_i, rd_start_i, rd_stop_i, rd_byte_i, temp_valid_o, standby_actual_bit_o;
    logic        fresh_result_flag_o, lost_result_flag_o, power_down_actual_bit_o;
    logic [15:0] mres1_i, mres2_i, mres3_i;
    logic [11:0] temp_raw_i;
    logic [23:0] conversion_span_counter_i;
    logic [3:0]  time_code_i;
    logic [7:0]  operation_select_reg_i;
    logic [2:0]  rd_addr_i;
    uvr_byte_t   rd_data_o, b;
    uvr_word_t   w;
    int          num_errors = 0;
    int          comparisons = 0;
    uvr_result_status u_uvr_result_status (.clk_i, .rstn_i, .ce_i, .meas_done_i, .meas_busy_i, .mres1_i,
        .mres2_i, .mres3_i, .temp_raw_i, .conversion_span_counter_i, .span_of_i, .mres_of_i, .adc_of_i,
        .standby_ctrl_i, .power_down_ctrl_i, .time_code_i, .external_sync_window_mode_i, .span_measure_enable_i,
        .operation_select_reg_i, .soft_reset_i, .config_state_i, .rd_start_i, .rd_stop_i, .rd_addr_i, .rd_byte_i,
        .rd_data_o, .fresh_result_flag_o, .lost_result_flag_o, .temp_valid_o, .standby_actual_bit_o,
        .power_down_actual_bit_o);
    uvr_host_model u_uvr_host_model (.clk_i, .rd_data_i(rd_data_o), .rd_start_o(rd_start_i),
        .rd_stop_o(rd_stop_i), .rd_byte_o(rd_byte_i), .rd_addr_o(rd_addr_i));
    // ********************
    // helpers
    // ********************
    always #20 clk_i = ~clk_i;
    task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    // one-cycle measurement strobe with mres2/3 derived from mres1
    task automatic meas(input logic [11:0] t, input logic [15:0] m, input logic [23:0] s, input logic [2:0] ov);
        tick(1);
        temp_raw_i = t;
        mres1_i = m;
        mres2_i = ~m;
        mres3_i = m ^ 16'h00ff;
        conversion_span_counter_i = s;
        {span_of_i, mres_of_i, adc_of_i} = ov;
        meas_done_i = 1'b1;
        tick(1);
        meas_done_i = 1'b0;
    endtask : meas
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    // watchdog: the tests need well under 2500 cycles
    initial begin
        #100000;
        num_errors++;
        end_sim();
    end
    // ********************
    // tests
    // ********************
    initial begin
        {rstn_i, meas_done_i, meas_busy_i, span_of_i, mres_of_i, adc_of_i, standby_ctrl_i} = '0;
        {power_down_ctrl_i, external_sync_window_mode_i, span_measure_enable_i, soft_reset_i, config_state_i} = '0;
        {mres1_i, mres2_i, mres3_i, temp_raw_i, conversion_span_counter_i} = '0;
        ce_i = 1'b1;
        time_code_i = 4'h2;
        operation_select_reg_i = 8'h5a;
        tick(16);
        rstn_i = 1'b1;
        chk("flags", {fresh_result_flag_o, lost_result_flag_o, temp_valid_o}, 3'h0);
        meas(12'habc, 16'h1234, 24'h0, 3'h0);
        tick(1);
        chk("fresh", fresh_result_flag_o, 1'b1);
        u_uvr_host_model.read_word(3'h1, w);
        chk("thermal", w, 16'h0abc);
        u_uvr_host_model.read_word(3'h2, w);
        chk("mres1", w, 16'h1234);
        chk("fresh", fresh_result_flag_o, 1'b0);
        $display("test basic done");
        meas(12'h111, 16'haaaa, 24'h0, 3'h5);
        meas(12'h222, 16'hbbbb, 24'h0, 3'h5);
        tick(1);
        chk("lost", lost_result_flag_o, 1'b1);
        u_uvr_host_model.read_word(3'h2, w);
        chk("mres1", w, 16'hbbbb);
        u_uvr_host_model.read_word(3'h3, w);
        chk("mres2", w, 16'h4444);
        u_uvr_host_model.read_word(3'h4, w);
        chk("mres3", w, 16'hbb44);
        chk("lost", lost_result_flag_o, 1'b1);
        u_uvr_host_model.read_word(3'h0, w);
        chk("status", w, 16'hb05a);
        chk("lost", lost_result_flag_o, 1'b0);
        $display("test lost done");
        meas(12'h333, 16'h0, 24'h0, 3'h0);
        u_uvr_host_model.start_rd(3'h1);
        meas(12'h444, 16'h0, 24'h0, 3'h0);
        u_uvr_host_model.get_byte(b);
        chk("frozen", b, 8'h33);
        u_uvr_host_model.stop_rd();
        u_uvr_host_model.read_word(3'h1, w);
        chk("thermal", w, 16'h0444);
        // status fetch lands in the cycle of an overwrite
        u_uvr_host_model.start_rd(3'h0);
        meas(12'h555, 16'h0, 24'h0, 3'h0);
        u_uvr_host_model.get_byte(b);
        fork
            u_uvr_host_model.get_byte(b);
            meas(12'h666, 16'h0, 24'h0, 3'h0);
        join
        u_uvr_host_model.stop_rd();
        tick(1);
        chk("lost", lost_result_flag_o, 1'b1);
        $display("test freeze done");
        for (int c = 0; c < 3; c++) begin
            time_code_i = c[3:0];
            meas(12'hfff, 16'h0, 24'h0, 3'h0);
            u_uvr_host_model.read_word(3'h1, w);
            chk("coarse", w, 16'h0fff & ~((16'h1 << (2 - c)) - 1));
        end
        external_sync_window_mode_i = 1'b1;
        for (int k = 0; k < 3; k++) begin
            span_measure_enable_i = (k != 0);
            meas(12'h789, 16'h0, 24'h000fff + k / 2, 3'h0);
            u_uvr_host_model.read_word(3'h1, w);
            chk("sync_word", w, (k == 0) ? 16'h0 : 16'h0789);
            chk("sync_valid", temp_valid_o, k == 2);
        end
        external_sync_window_mode_i = 1'b0;
        $display("test thermal done");
        for (int k = 0; k < 2; k++) begin
            u_uvr_host_model.start_rd(3'h1);
            {soft_reset_i, config_state_i} = k ? 2'b01 : 2'b10;
            tick(1);
            {soft_reset_i, config_state_i} = 2'b00;
            u_uvr_host_model.get_byte(b);
            chk("cleared", b, 8'h00);
            u_uvr_host_model.stop_rd();
            chk("valid_clr", temp_valid_o, 1'b0);
        end
        $display("test clear done");
        for (int k = 0; k < 2; k++) begin
            {meas_busy_i, standby_ctrl_i, power_down_ctrl_i} = k ? 3'b101 : 3'b110;
            tick(1);
            chk("state_bits", {standby_actual_bit_o, power_down_actual_bit_o}, k ? 2'b01 : 2'b10);
            u_uvr_host_model.read_word(3'h0, w);
            chk("status", w[10:8], k ? 3'b101 : 3'b110);
        end
        $display("test state done");
        // a strobe while the enable is low must leave the buffer alone
        ce_i = 1'b0;
        meas(12'h0aa, 16'h0, 24'h0, 3'h0);
        ce_i = 1'b1;
        u_uvr_host_model.read_word(3'h1, w);
        chk("ce_hold", w, 16'h0789);
        $display("test enable done");
        end_sim();
    end
endmodule : uvr_result_status_tb

bind uvr_result_status uvr_result_status_asserts u_chk (.clk_i, .rstn_i, .ce_i, .meas_done_i, .rd_start_i,
    .rd_byte_i, .soft_reset_i, .config_state_i, .standby_ctrl_i, .power_down_ctrl_i, .rd_data_o,
    .fresh_result_flag_o, .lost_result_flag_o, .temp_valid_o, .standby_actual_bit_o, .power_down_actual_bit_o);
